// file: core/osd_cfg.svh
// Constants for the orientation and shake detector
`ifndef OSD_CFG_SVH
`define OSD_CFG_SVH

// ----------------------------------------
// Register map and identity
// ----------------------------------------
`define OSD_I2C_ADDR      7'h16
`define OSD_REG_X         8'h00
`define OSD_REG_Y         8'h01
`define OSD_REG_STAT      8'h02
`define OSD_REG_CFG       8'h04
`define OSD_REG_ID        8'h08
// Arbitrary value
`define OSD_PART_CODE     6'h2a
`define OSD_REG_RESET     8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OSD_CFG_SLEEP     7
`define OSD_CFG_MODE      6
`define OSD_CFG_LVL       5:4
`define OSD_CFG_WIN       3:2
`define OSD_CFG_HOLD      1:0
`define OSD_ST_IRQ        7
`define OSD_ST_JOLT       6:5
`define OSD_ST_TILT       4
`define OSD_ST_INST       3:2
`define OSD_ST_LT         1:0

// ----------------------------------------
// Codes
// ----------------------------------------
`define OSD_FACE_UP       2'h0
`define OSD_FACE_CW       2'h1
`define OSD_FACE_INV      2'h2
`define OSD_FACE_CCW      2'h3
`define OSD_JOLT_NONE     2'h0
`define OSD_JOLT_LEFT     2'h1
`define OSD_JOLT_RIGHT    2'h2

// ----------------------------------------
// Scale and timing
// ----------------------------------------
`define OSD_LSB_PER_G     64
`define OSD_MIN_SIG       (3 * `OSD_LSB_PER_G / 8)
`define OSD_HALF_G        (`OSD_LSB_PER_G / 2)
`define OSD_MEAS_HZ       100
`define OSD_MS_PER_S      1000
`define OSD_HOLD0_MS      160
`define OSD_HOLD1_MS      320
`define OSD_HOLD2_MS      640
`define OSD_HOLD3_MS      1280
`define OSD_WIN0_MS       80
`define OSD_WIN1_MS       160
`define OSD_WIN2_MS       320
`define OSD_WIN3_MS       640
`define OSD_CNT_MIN1(c)   (((c) < 1) ? 1 : (c))
`define OSD_CEIL_CNT(ms)  `OSD_CNT_MIN1(((ms) * `OSD_MEAS_HZ + `OSD_MS_PER_S - 1) / `OSD_MS_PER_S)
`define OSD_FLOOR_CNT(ms) `OSD_CNT_MIN1((ms) * `OSD_MEAS_HZ / `OSD_MS_PER_S)

`endif

// file: core/osd_pkg.sv
// Types for the orientation and shake detector
package osd_pkg;
    typedef enum logic {
        JOLT_IDLE,
        JOLT_ARMED
    } osd_jolt_state_t;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ACK,
        I2C_RX,
        I2C_TX,
        I2C_RACK
    } osd_i2c_state_t;
endpackage

// file: core/osd_i2c.sv
// Serial register port slave with auto-incrementing pointer
`include "osd_cfg.svh"

module osd_i2c
    import osd_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic [7:0]      reg_ptr,
    input  wire logic [7:0] rd_data,
    output logic            rd_pulse,
    output logic            wr_pulse,
    output logic [7:0]      wr_data
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic           scl_s1, scl_s2, scl_d;
    logic           sda_s1, sda_s2, sda_d;
    logic           scl_rise, scl_fall, start_cond, stop_cond;
    osd_i2c_state_t state;
    logic [7:0]     shift;
    logic [3:0]     bit_cnt;
    logic           rw;
    logic           first_byte;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_s1 <= scl;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    assign scl_rise   = scl_s2 & ~scl_d;
    assign scl_fall   = ~scl_s2 & scl_d;
    assign start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_cond  = scl_s2 & scl_d & ~sda_d & sda_s2;
    // Open drain: only ever pulls low
    assign sda_out    = 1'b0;

    // ----------------------------------------
    // Byte engine
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= I2C_IDLE;
            shift      <= `OSD_REG_RESET;
            bit_cnt    <= 4'h0;
            rw         <= 1'b0;
            first_byte <= 1'b0;
            sda_oe     <= 1'b0;
            reg_ptr    <= `OSD_REG_RESET;
            rd_pulse   <= 1'b0;
            wr_pulse   <= 1'b0;
            wr_data    <= `OSD_REG_RESET;
        end else begin
            rd_pulse <= 1'b0;
            wr_pulse <= 1'b0;
            // Advance only after the top has used the pointer for this byte
            if (rd_pulse || wr_pulse) begin
                reg_ptr <= reg_ptr + 8'h01;
            end
            if (start_cond) begin
                state      <= I2C_ADDR;
                bit_cnt    <= 4'h0;
                first_byte <= 1'b1;
                sda_oe     <= 1'b0;
            end else if (stop_cond) begin
                state  <= I2C_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    I2C_ADDR, I2C_RX: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_s2};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            if (state == I2C_ADDR) begin
                                if (shift[7:1] == `OSD_I2C_ADDR) begin
                                    sda_oe <= 1'b1;
                                    rw     <= shift[0];
                                    state  <= I2C_ACK;
                                end else begin
                                    state <= I2C_IDLE;
                                end
                            end else begin
                                if (first_byte) begin
                                    reg_ptr    <= shift;
                                    first_byte <= 1'b0;
                                end else begin
                                    wr_pulse <= 1'b1;
                                    wr_data  <= shift;
                                end
                                sda_oe <= 1'b1;
                                state  <= I2C_ACK;
                            end
                        end
                    end
                    I2C_ACK: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (rw) begin
                                shift    <= rd_data;
                                sda_oe   <= ~rd_data[7];
                                rd_pulse <= 1'b1;
                                state    <= I2C_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                state  <= I2C_RX;
                            end
                        end
                    end
                    I2C_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt == 4'h7) begin
                                sda_oe <= 1'b0;
                                state  <= I2C_RACK;
                            end else begin
                                shift   <= {shift[6:0], 1'b0};
                                sda_oe  <= ~shift[6];
                                bit_cnt <= bit_cnt + 4'h1;
                            end
                        end
                    end
                    I2C_RACK: begin
                        // A missing acknowledge ends the read burst
                        if (scl_rise) begin
                            state <= sda_s2 ? I2C_IDLE : I2C_ACK;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

// file: core/osd_top.sv
// Orientation and shake detector with serial register port
`include "osd_cfg.svh"

module osd_top
    import osd_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [7:0] x_sample,
    input  wire logic [7:0] y_sample,
    input  wire logic       sample_strobe,
    output logic            irq_pin,
    output logic            sleep_mode
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [8:0] mag(input logic [7:0] v);
        mag = v[7] ? 9'(-$signed({v[7], v})) : {1'b0, v};
    endfunction

    function automatic logic [1:0] facing(input logic [7:0] x, input logic [7:0] y);
        logic [8:0] s;
        logic [8:0] d;
        s = 9'($signed({x[7], x}) + $signed({y[7], y}));
        d = 9'($signed({x[7], x}) - $signed({y[7], y}));
        case ({s[8], d[8]})
            2'b01:   facing = `OSD_FACE_UP;
            2'b00:   facing = `OSD_FACE_CW;
            2'b10:   facing = `OSD_FACE_INV;
            default: facing = `OSD_FACE_CCW;
        endcase
    endfunction

    function automatic logic [7:0] hold_len(input logic [1:0] sel);
        case (sel)
            2'h0:    hold_len = 8'(`OSD_CEIL_CNT(`OSD_HOLD0_MS));
            2'h1:    hold_len = 8'(`OSD_CEIL_CNT(`OSD_HOLD1_MS));
            2'h2:    hold_len = 8'(`OSD_CEIL_CNT(`OSD_HOLD2_MS));
            default: hold_len = 8'(`OSD_CEIL_CNT(`OSD_HOLD3_MS));
        endcase
    endfunction

    function automatic logic [7:0] win_len(input logic [1:0] sel);
        case (sel)
            2'h0:    win_len = 8'(`OSD_FLOOR_CNT(`OSD_WIN0_MS));
            2'h1:    win_len = 8'(`OSD_FLOOR_CNT(`OSD_WIN1_MS));
            2'h2:    win_len = 8'(`OSD_FLOOR_CNT(`OSD_WIN2_MS));
            default: win_len = 8'(`OSD_FLOOR_CNT(`OSD_WIN3_MS));
        endcase
    endfunction

    function automatic logic [8:0] jolt_th(input logic [1:0] sel);
        jolt_th = 9'(({7'h00, sel} + 9'h001) * `OSD_HALF_G);
    endfunction

    // ----------------------------------------
    // Registers and wires
    // ----------------------------------------
    logic [7:0]      x_accel_byte;
    logic [7:0]      y_accel_byte;
    logic [7:0]      detect_config;
    logic [1:0]      long_term_facing;
    logic [1:0]      instant_facing;
    logic [1:0]      cand_facing;
    logic [7:0]      hold_cnt;
    logic            tilt;
    logic [1:0]      jolt_result;
    logic            shake_lock;
    logic            irq_flag;
    osd_jolt_state_t jolt_state;
    logic            first_neg;
    logic [7:0]      win_cnt;
    logic [7:0]      reg_ptr;
    logic [7:0]      rd_data;
    logic            rd_pulse;
    logic            wr_pulse;
    logic [7:0]      wr_data;
    logic            meas_go;
    logic            sig_ok;
    logic [1:0]      new_facing;
    logic [7:0]      next_hold;
    logic            lt_change;
    logic [7:0]      perp;
    logic            over_th;
    logic [7:0]      next_win;
    logic            in_win;
    logic            shake_hit;
    logic            status_rd;

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    osd_i2c u_i2c (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .scl      (scl),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .reg_ptr  (reg_ptr),
        .rd_data  (rd_data),
        .rd_pulse (rd_pulse),
        .wr_pulse (wr_pulse),
        .wr_data  (wr_data)
    );

    always_comb begin
        case (reg_ptr)
            `OSD_REG_X:    rd_data = x_accel_byte;
            `OSD_REG_Y:    rd_data = y_accel_byte;
            `OSD_REG_STAT: rd_data = {irq_flag, jolt_result, tilt, instant_facing, long_term_facing};
            `OSD_REG_ID:   rd_data = {2'b00, `OSD_PART_CODE};
            default:       rd_data = `OSD_REG_RESET;
        endcase
    end

    assign status_rd = rd_pulse && reg_ptr == `OSD_REG_STAT;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            detect_config <= `OSD_REG_RESET;
        end else if (wr_pulse && reg_ptr == `OSD_REG_CFG) begin
            detect_config <= wr_data;
        end
    end

    // Power-down freezes detection but keeps the port alive, so software can wake it
    assign sleep_mode = detect_config[`OSD_CFG_SLEEP];
    assign meas_go    = sample_strobe && !detect_config[`OSD_CFG_SLEEP];

    // ----------------------------------------
    // Samples and facing
    // ----------------------------------------
    assign sig_ok     = mag(x_sample) >= 9'(`OSD_MIN_SIG) || mag(y_sample) >= 9'(`OSD_MIN_SIG);
    assign new_facing = facing(x_sample, y_sample);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            x_accel_byte <= `OSD_REG_RESET;
            y_accel_byte <= `OSD_REG_RESET;
        end else if (meas_go) begin
            x_accel_byte <= x_sample;
            y_accel_byte <= y_sample;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tilt           <= 1'b0;
            instant_facing <= `OSD_FACE_UP;
        end else if (meas_go) begin
            tilt <= !sig_ok;
            if (sig_ok) begin
                instant_facing <= new_facing;
            end
        end
    end

    // Filter needs an unbroken run; any invalid sample restarts it
    assign next_hold = (new_facing == cand_facing) ? hold_cnt + 8'h01 : 8'h01;
    assign lt_change = meas_go && sig_ok && new_facing != long_term_facing
                       && next_hold >= hold_len(detect_config[`OSD_CFG_HOLD]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            long_term_facing <= `OSD_FACE_UP;
            cand_facing      <= `OSD_FACE_UP;
            hold_cnt         <= 8'h00;
        end else if (meas_go) begin
            if (!sig_ok || new_facing == long_term_facing) begin
                hold_cnt    <= 8'h00;
                cand_facing <= long_term_facing;
            end else if (lt_change) begin
                long_term_facing <= new_facing;
                hold_cnt         <= 8'h00;
            end else begin
                cand_facing <= new_facing;
                hold_cnt    <= next_hold;
            end
        end
    end

    // ----------------------------------------
    // Shake detection
    // ----------------------------------------
    assign perp     = long_term_facing[0] ? x_sample : y_sample;
    assign over_th  = mag(perp) > jolt_th(detect_config[`OSD_CFG_LVL]);
    assign next_win = win_cnt + 8'h01;
    assign in_win   = next_win <= win_len(detect_config[`OSD_CFG_WIN]);
    assign shake_hit = meas_go && jolt_state == JOLT_ARMED && in_win && perp[7] != first_neg
                       && (detect_config[`OSD_CFG_MODE] || over_th);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            jolt_state <= JOLT_IDLE;
            first_neg  <= 1'b0;
            win_cnt    <= 8'h00;
        end else if (meas_go) begin
            case (jolt_state)
                JOLT_IDLE: begin
                    if (!shake_lock && over_th) begin
                        jolt_state <= JOLT_ARMED;
                        first_neg  <= perp[7];
                        win_cnt    <= 8'h00;
                    end
                end
                JOLT_ARMED: begin
                    if (shake_hit || !in_win) begin
                        jolt_state <= JOLT_IDLE;
                    end else begin
                        win_cnt <= next_win;
                    end
                end
                default: begin
                    jolt_state <= JOLT_IDLE;
                end
            endcase
        end
    end

    // Set beats the clearing read, so a shake is never lost
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            jolt_result <= `OSD_JOLT_NONE;
            shake_lock  <= 1'b0;
        end else if (shake_hit) begin
            jolt_result <= first_neg ? `OSD_JOLT_LEFT : `OSD_JOLT_RIGHT;
            shake_lock  <= 1'b1;
        end else if (status_rd) begin
            jolt_result <= `OSD_JOLT_NONE;
            shake_lock  <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag <= 1'b0;
        end else if (lt_change || shake_hit) begin
            irq_flag <= 1'b1;
        end else if (status_rd) begin
            irq_flag <= 1'b0;
        end
    end

    assign irq_pin = irq_flag;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_event;
        lt_change || shake_hit;
    endsequence

    a_irq_cause: assert property ($rose(irq_pin) |-> $past(lt_change || shake_hit))
        else $error("irq rose without cause");
    a_irq_clear: assert property (status_rd && !(lt_change || shake_hit) |=> !irq_pin)
        else $error("status read did not clear irq");
    a_irq_set: assert property (s_event |=> irq_pin ##0 irq_flag)
        else $error("event did not raise irq pin");
    a_tilt_track: assert property (meas_go |=> tilt == !$past(sig_ok))
        else $error("tilt not updated");
    a_inst_track: assert property (meas_go && sig_ok |=> instant_facing == $past(new_facing))
        else $error("instant facing not updated");
    a_lt_hold: assert property ($changed(long_term_facing)
                                |-> $past(next_hold) >= $past(hold_len(detect_config[`OSD_CFG_HOLD])))
        else $error("long-term facing changed early");
    a_shake_lock: assert property (shake_lock && !status_rd |=> $stable(jolt_result))
        else $error("shake result changed while locked");
    a_jolt_code: assert property (jolt_result != 2'h3)
        else $error("undefined shake code");
    a_sleep_freeze: assert property (sleep_mode && !wr_pulse |=> $stable(x_accel_byte) && $stable(tilt))
        else $error("samples moved while asleep");
    a_cfg_write: assert property (wr_pulse && reg_ptr == `OSD_REG_CFG |=> detect_config == $past(wr_data))
        else $error("config write lost");

endmodule

// file: bench/osd_mst.sv
// Serial bus master model for the register port
module osd_mst (
    output logic     scl,
    output logic     sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 10ps;
    // ----
    // Bus phases, a quarter bit each
    // ----
    localparam realtime Q = 31.25;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Also serves as repeated start; data is released while clock is low, then pulled low while clock is high
    task automatic start;
        #Q sda_low = 1'b0;
        #Q scl = 1'b1;
        #Q sda_low = 1'b1;
        #Q scl = 1'b0;
    endtask
    task automatic stop;
        #Q sda_low = 1'b1;
        #Q scl = 1'b1;
        #Q sda_low = 1'b0;
        #Q;
    endtask
    // Ninth bit is the acknowledge; released bits read back the slave
    task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] r, output logic ack);
        logic [8:0] v;
        v = {d, nak};
        for (int i = 8; i >= 0; i--) begin
            #Q sda_low = !v[i];
            #Q scl = 1'b1;
            #Q v[i] = sda;
            #Q scl = 1'b0;
        end
        r = v[8:1];
        ack = !v[0];
    endtask
endmodule

// file: bench/osd_top_tb_top.sv
// Self-checking bench for the orientation and shake detector
`include "osd_cfg.svh"
module osd_top_tb_top;
    timeunit 1ns;
    timeprecision 10ps;
    // ----
    // Stimulus, reference model and checks
    // ----
    logic        mclk = 1'b0, rst_n = 1'b0, sample_strobe = 1'b0;
    logic [7:0]  x_sample = 8'h00, y_sample = 8'h00, cfg = 8'h00, rb;
    logic        scl, m_low, sda_out, sda_oe, irq_pin, sleep_mode, ack;
    logic [31:0] seed = 32'h048c32d5;
    wire         sda = !(m_low | (sda_oe & !sda_out));
    int          n_mismatch = 0, cmp_count = 0, lt, ist, tl, irq, js, lk, arm, ng, w, rn, cd, mx, my;
    always #2.5 mclk = !mclk;
    osd_top osd_top_i (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .x_sample(x_sample), .y_sample(y_sample), .sample_strobe(sample_strobe),
        .irq_pin(irq_pin), .sleep_mode(sleep_mode));
    osd_mst osd_mst_i (.scl(scl), .sda_low(m_low), .sda(sda));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic bx(input logic [7:0] d, input logic n = 1'b1);
        osd_mst_i.xfer(d, n, rb, ack);
    endtask
    // Starts one below the config so the pointer must advance past an ignored byte
    task automatic setcfg(input logic [7:0] c);
        osd_mst_i.start();
        bx({`OSD_I2C_ADDR, 1'b0});
        bx(8'h03);
        bx(8'h5a);
        bx(c);
        osd_mst_i.stop();
        cfg = c;
        chk("sleep_mode", {7'h0, sleep_mode}, {7'h0, c[7]});
    endtask
    task automatic rdc(input int p, input int n);
        logic [7:0] e;
        osd_mst_i.start();
        bx({`OSD_I2C_ADDR, 1'b0});
        bx(p[7:0]);
        osd_mst_i.start();
        bx({`OSD_I2C_ADDR, 1'b1});
        for (int a = p; a < p + n; a++) begin
            bx(8'hff, a == p + n - 1);
            e = a == 0 ? mx : a == 1 ? my : a == 2 ? irq * 128 + js * 32 + tl * 16 + ist * 4 + lt : a == 8 ? `OSD_PART_CODE : 0;
            if (a == 8) rb[7:6] = 2'b00;
            chk($sformatf("reg%0h", a), rb, e);
            if (a == 2) {irq, js, lk} = 0;
        end
        osd_mst_i.stop();
    endtask
    // Shake axis is taken from long-term facing before this sample updates it
    task automatic smp(input int x, input int y);
        int a, t, f;
        @(negedge mclk);
        x_sample = x[7:0];
        y_sample = y[7:0];
        sample_strobe = 1'b1;
        @(negedge mclk);
        sample_strobe = 1'b0;
        if (!cfg[7]) begin
            a = lt % 2 ? x : y;
            t = 32 * (cfg[5:4] + 1);
            if (!lk && !arm && (a > t || -a > t)) begin
                arm = 1;
                ng = a < 0;
                w = 0;
            end else if (!lk && arm) begin
                w++;
                if (w > (8 << cfg[3:2])) arm = 0;
                else if ((a < 0) != ng && (cfg[6] || a > t || -a > t)) begin
                    js = 2 - ng;
                    lk = 1;
                    irq = 1;
                    arm = 0;
                end
            end
            mx = x;
            my = y;
            tl = x < 24 && x > -24 && y < 24 && y > -24;
            f = x + y >= 0 ? (x - y < 0 ? 0 : 1) : (x - y >= 0 ? 2 : 3);
            if (!tl) ist = f;
            rn = tl || f == lt ? 0 : f == cd ? rn + 1 : 1;
            cd = f;
            if (rn >= (16 << cfg[1:0])) begin
                lt = f;
                irq = 1;
                rn = 0;
            end
        end
        @(negedge mclk);
        chk("irq_pin", {7'h0, irq_pin}, irq[7:0]);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        rdc(0, 3);
        rdc(8, 1);
        osd_mst_i.start();
        bx({7'h17, 1'b0});
        chk("addr_ack", {7'h0, ack}, 8'h00);
        osd_mst_i.stop();
        $display("test reset and identity done");
        // Top level keeps random data from starting a shake
        setcfg(8'h30);
        rdc(4, 1);
        repeat (12) begin
            r = xs();
            smp($signed(r[7:0]), $signed(r[15:8]));
            rdc(0, 3);
        end
        repeat (17) smp(64, 0);
        rdc(2, 1);
        $display("test facing done");
        setcfg(8'h00);
        repeat (2) begin
            smp(-40, 0);
            smp(40, 0);
        end
        rdc(2, 1);
        rdc(2, 1);
        setcfg(8'h40);
        smp(40, 0);
        smp(-1, 0);
        rdc(2, 1);
        setcfg(8'h00);
        for (int k = 7; k <= 8; k++) begin
            smp(40, 0);
            repeat (k) smp(0, 0);
            smp(-40, 0);
            rdc(2, 1);
        end
        // Level, window and hold selections stepped together
        for (int s = 1; s < 4; s++) begin
            setcfg({2'b00, 2'(s), 2'(s), 2'(s)});
            smp(100, 0);
            repeat ((8 << s) - 1) smp(0, 0);
            smp(-100, 0);
            rdc(2, 1);
            repeat (16 << s) smp(-100, 0);
            rdc(2, 1);
        end
        $display("test shake done");
        setcfg(8'h80);
        smp(100, 100);
        rdc(0, 1);
        setcfg(8'h00);
        $display("test sleep done");
        report_and_stop();
    end
    initial begin
        #400us;
        n_mismatch++;
        report_and_stop();
    end
endmodule
